// ==== logic/stc_pkg.sv ====
// Shared constants and types for the transmit-channel configuration bank.
package stc_pkg;
    localparam int          MAX_PORTS    = 4;
    localparam int          ADDR_W       = 12;
    localparam int          CFG_W        = 17;
    localparam logic [11:0] OFS_TX_CFG0  = 12'h110;
    localparam logic [11:0] OFS_TX_CFG1  = 12'h114;
    localparam logic [11:0] OFS_TX_CFG2  = 12'h118;
    localparam logic [11:0] OFS_TX_CFG3  = 12'h11C;
    localparam logic [11:0] OFS_STATUS   = 12'h140;
    localparam logic [11:0] OFS_ERROR    = 12'h144;
    localparam int          POS_FIXPH    = 16;
    localparam int          POS_PREEMPH  = 12;
    localparam int          PREEMPH_W    = 4;
    localparam int          POS_SWING    = 9;
    localparam int          SWING_W      = 3;
    localparam int          POS_CM       = 8;
    localparam int          POS_POL      = 7;
    localparam int          POS_RATE     = 5;
    localparam int          RATE_W       = 2;
    localparam int          POS_WIDTH    = 2;
    localparam int          WIDTH_W      = 3;
    localparam int          POS_RSVD1    = 1;
    localparam int          POS_TX_ON    = 0;
    localparam logic [16:0] CFG_RESET    = 17'h0_0000;
    localparam logic [2:0]  WIDTH_10BIT  = 3'h0;
    localparam logic [3:0]  ERR_RESET    = 4'h0;

    typedef enum logic [1:0] {
        STC_RATE_FULL    = 2'h0,
        STC_RATE_HALF    = 2'h1,
        STC_RATE_QUARTER = 2'h2,
        STC_RATE_RSVD    = 2'h3
    } stc_rate_t;

    typedef enum logic {
        STC_APB_IDLE   = 1'b0,
        STC_APB_ACCESS = 1'b1
    } stc_apb_st_t;
endpackage : stc_pkg

// ==== logic/stc_cfg_if.sv ====
// Carrier between the register bank and one transmit lane controller.
`timescale 1ns/1ps
interface stc_cfg_if;
    logic [16:0] cfg;
    logic        lane_ok;

    modport bank (output cfg, input lane_ok);
    modport lane (input cfg, output lane_ok);
endinterface : stc_cfg_if

// ==== logic/stc_lane.sv ====
// One transmit lane controller: registers the fields that steer the analog lane.
`timescale 1ns/1ps
module stc_lane (
    input  wire logic        i_clock,
    input  wire logic        i_rst,
    stc_cfg_if.lane          cfg_if,
    output logic             o_transmitter_on,
    output logic             o_fixed_phase_en,
    output logic [3:0]       o_tx_preemph_level,
    output logic [2:0]       o_tx_swing,
    output logic             o_common_mode_raise,
    output logic             o_tx_polarity_flip,
    output logic [1:0]       o_tx_rate,
    output logic [2:0]       o_parallel_width_sel,
    output logic             o_sample_stb
);
    logic [1:0] div_q;
    logic       ok;
    logic       stb_d;

    // The lane runs only with the phase lock on, the 10-bit bus and a legal rate.
    assign ok = cfg_if.cfg[stc_pkg::POS_TX_ON] & cfg_if.cfg[stc_pkg::POS_FIXPH]
              & (cfg_if.cfg[stc_pkg::POS_WIDTH +: stc_pkg::WIDTH_W] == stc_pkg::WIDTH_10BIT)
              & (cfg_if.cfg[stc_pkg::POS_RATE +: stc_pkg::RATE_W] != stc_pkg::STC_RATE_RSVD);
    assign cfg_if.lane_ok = ok;

    always_comb begin
        case (cfg_if.cfg[stc_pkg::POS_RATE +: stc_pkg::RATE_W]) // [RULE8]
            stc_pkg::STC_RATE_FULL:    stb_d = ok;
            stc_pkg::STC_RATE_HALF:    stb_d = ok & (div_q[0] == 1'b0);
            stc_pkg::STC_RATE_QUARTER: stb_d = ok & (div_q == 2'h0);
            default:                   stb_d = 1'b0;
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            div_q <= 2'h0;
        end else if (!ok) begin
            div_q <= 2'h0;
        end else begin
            div_q <= div_q + 2'h1;
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_transmitter_on     <= 1'b0;
            o_fixed_phase_en     <= 1'b0;
            o_tx_preemph_level   <= 4'h0;
            o_tx_swing           <= 3'h0;
            o_common_mode_raise  <= 1'b0;
            o_tx_polarity_flip   <= 1'b0;
            o_tx_rate            <= 2'h0;
            o_parallel_width_sel <= 3'h0;
            o_sample_stb         <= 1'b0;
        end else begin
            o_transmitter_on     <= ok; // [RULE12]
            o_fixed_phase_en     <= cfg_if.cfg[stc_pkg::POS_FIXPH];
            o_tx_preemph_level   <= cfg_if.cfg[stc_pkg::POS_PREEMPH +: stc_pkg::PREEMPH_W]; // [RULE4]
            o_tx_swing           <= cfg_if.cfg[stc_pkg::POS_SWING +: stc_pkg::SWING_W]; // [RULE5]
            o_common_mode_raise  <= cfg_if.cfg[stc_pkg::POS_CM]; // [RULE6]
            o_tx_polarity_flip   <= cfg_if.cfg[stc_pkg::POS_POL]; // [RULE7]
            o_tx_rate            <= cfg_if.cfg[stc_pkg::POS_RATE +: stc_pkg::RATE_W];
            o_parallel_width_sel <= cfg_if.cfg[stc_pkg::POS_WIDTH +: stc_pkg::WIDTH_W];
            o_sample_stb         <= stb_d;
        end
    end
endmodule : stc_lane

// ==== logic/stc_tx_cfg.sv ====
// Transmit-channel configuration bank: APB slave, per-port registers and lanes.
`timescale 1ns/1ps

// Contract
// [RULE1] Four per-port transmit configuration registers at 0x110, 0x114, 0x118, 0x11C.
// [RULE2] Bits 31 to 17 are read-only, read zero and ignore writes.
// [RULE3] Software writes the fixed-phase enable at bit 16 only as one.
// [RULE4] Bits 15 to 12 choose the de-emphasis level; zero means none.
// [RULE5] Bits 11 to 9 choose one of eight output swing levels.
// [RULE6] Bit 8 raises the transmit common mode when set.
// [RULE7] Bit 7 swaps the positive and negative output lines when set.
// [RULE8] Bits 6 to 5 choose full, half or quarter rate; 11 is reserved.
// [RULE9] Software writes 000 to bits 4 to 2, the 10-bit parallel bus.
// [RULE10] Software writes zero to reserved bit 1.
// [RULE11] Bits 16 to 0 are read/write and reset to zero.
// [RULE12] Bit 0 turns the port transmitter on when set, off when clear; the lane also needs bit 16 set, bits 4 to 2 at 000 and rate not 11.
module stc_tx_cfg #(
    parameter int NUM_PORTS = 4
) (
    input  wire logic                   i_clock,
    input  wire logic                   i_rst,
    input  wire logic                   i_psel,
    input  wire logic                   i_penable,
    input  wire logic                   i_pwrite,
    input  wire logic [11:0]            i_paddr,
    input  wire logic [31:0]            i_pwdata,
    input  wire logic [3:0]             i_pstrb,
    output logic      [31:0]            o_prdata,
    output logic                        o_pready,
    output logic                        o_pslverr,
    output logic      [NUM_PORTS-1:0]   o_transmitter_on,
    output logic      [NUM_PORTS-1:0]   o_fixed_phase_en,
    output logic      [NUM_PORTS*4-1:0] o_tx_preemph_level,
    output logic      [NUM_PORTS*3-1:0] o_tx_swing,
    output logic      [NUM_PORTS-1:0]   o_common_mode_raise,
    output logic      [NUM_PORTS-1:0]   o_tx_polarity_flip,
    output logic      [NUM_PORTS*2-1:0] o_tx_rate,
    output logic      [NUM_PORTS*3-1:0] o_parallel_width_sel,
    output logic      [NUM_PORTS-1:0]   o_sample_stb
);

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------

    localparam logic [11:0] CFG_OFS [stc_pkg::MAX_PORTS] = '{
        stc_pkg::OFS_TX_CFG0,
        stc_pkg::OFS_TX_CFG1,
        stc_pkg::OFS_TX_CFG2,
        stc_pkg::OFS_TX_CFG3
    };

    stc_pkg::stc_apb_st_t st_q;
    stc_pkg::stc_apb_st_t st_d;

    logic [NUM_PORTS-1:0] hit_cfg;
    logic                 hit_status;
    logic                 hit_error;
    logic                 mapped;
    logic                 setup;
    logic                 wr_done;
    logic [16:0]          wmask;
    logic [3:0]           lane_ok;
    logic [3:0]           err_q;
    logic [3:0]           err_set;
    logic [3:0]           err_clr;
    logic [31:0]          rd_mux;
    logic [16:0]          cfg_q [NUM_PORTS];

    // Ports beyond NUM_PORTS have no register, so their offsets answer as unmapped.
    genvar gi;
    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_dec
            assign hit_cfg[gi] = (i_paddr == CFG_OFS[gi]); // [RULE1]
        end
    endgenerate

    assign hit_status = (i_paddr == stc_pkg::OFS_STATUS);
    assign hit_error  = (i_paddr == stc_pkg::OFS_ERROR);
    assign mapped     = (|hit_cfg) | hit_status | hit_error;

    // ------------------------------------------------------------------
    // APB handshake
    // ------------------------------------------------------------------

    // One fixed wait-free answer: pready rises in the first access cycle.
    assign setup   = i_psel & ~i_penable;
    assign wr_done = i_psel & i_penable & o_pready & i_pwrite;

    always_comb begin
        st_d = st_q;
        case (st_q)
            stc_pkg::STC_APB_IDLE: begin
                if (setup) begin
                    st_d = stc_pkg::STC_APB_ACCESS;
                end
            end
            stc_pkg::STC_APB_ACCESS: begin
                if (i_psel & i_penable) begin
                    st_d = stc_pkg::STC_APB_IDLE;
                end
            end
            default: begin
                st_d = stc_pkg::STC_APB_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            st_q     <= stc_pkg::STC_APB_IDLE;
            o_pready <= 1'b0;
        end else begin
            st_q     <= st_d;
            o_pready <= (st_d == stc_pkg::STC_APB_ACCESS);
        end
    end

    // ------------------------------------------------------------------
    // Byte strobes
    // ------------------------------------------------------------------

    // Lane 2 carries only bit 16; lane 3 holds read-only bits alone.
    assign wmask = {i_pstrb[2], {8{i_pstrb[1]}}, {8{i_pstrb[0]}}}; // [RULE2]

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------

    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_reg
            always_ff @(posedge i_clock or posedge i_rst) begin
                if (i_rst) begin
                    cfg_q[gi] <= stc_pkg::CFG_RESET; // [RULE11]
                end else if (wr_done && hit_cfg[gi]) begin
                    cfg_q[gi] <= (cfg_q[gi] & ~wmask) | (i_pwdata[16:0] & wmask); // [RULE11]
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------------
    // Lane controllers
    // ------------------------------------------------------------------

    generate
        for (gi = 0; gi < NUM_PORTS; gi++) begin : g_lane
            stc_cfg_if lane_if ();

            assign lane_if.cfg  = cfg_q[gi];
            assign lane_ok[gi]  = lane_if.lane_ok;

            stc_lane u_lane (
                .i_clock              (i_clock),
                .i_rst                (i_rst),
                .cfg_if               (lane_if),
                .o_transmitter_on     (o_transmitter_on[gi]),
                .o_fixed_phase_en     (o_fixed_phase_en[gi]),
                .o_tx_preemph_level   (o_tx_preemph_level[gi*4 +: 4]),
                .o_tx_swing           (o_tx_swing[gi*3 +: 3]),
                .o_common_mode_raise  (o_common_mode_raise[gi]),
                .o_tx_polarity_flip   (o_tx_polarity_flip[gi]),
                .o_tx_rate            (o_tx_rate[gi*2 +: 2]),
                .o_parallel_width_sel (o_parallel_width_sel[gi*3 +: 3]),
                .o_sample_stb         (o_sample_stb[gi])
            );
        end
        for (gi = NUM_PORTS; gi < stc_pkg::MAX_PORTS; gi++) begin : g_absent
            assign lane_ok[gi] = 1'b0;
        end
    endgenerate

    // ------------------------------------------------------------------
    // Reserved-code watch
    // ------------------------------------------------------------------

    // A port is flagged when its written value holds a code that software must
    // not use; except for a set reserved bit 1, the lane then stays off, so the flag explains a dead output.
    generate
        for (gi = 0; gi < stc_pkg::MAX_PORTS; gi++) begin : g_err
            if (gi < NUM_PORTS) begin : g_on
                logic [16:0] nv;
                assign nv = (cfg_q[gi] & ~wmask) | (i_pwdata[16:0] & wmask);
                assign err_set[gi] = wr_done & hit_cfg[gi]
                    & (~nv[stc_pkg::POS_FIXPH] // [RULE3]
                    | (nv[stc_pkg::POS_WIDTH +: stc_pkg::WIDTH_W] != stc_pkg::WIDTH_10BIT) // [RULE9]
                    | nv[stc_pkg::POS_RSVD1] // [RULE10]
                    | (nv[stc_pkg::POS_RATE +: stc_pkg::RATE_W] == stc_pkg::STC_RATE_RSVD)); // [RULE8]
            end else begin : g_off
                assign err_set[gi] = 1'b0;
            end
        end
    endgenerate

    assign err_clr = (wr_done && hit_error) ? i_pwdata[3:0] : 4'h0;

    // Write-one-to-clear; a new offence in the clearing cycle keeps its flag.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            err_q <= stc_pkg::ERR_RESET;
        end else begin
            err_q <= (err_q & ~err_clr) | err_set;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------

    always_comb begin
        rd_mux = 32'h0000_0000;
        for (int i = 0; i < NUM_PORTS; i++) begin
            if (hit_cfg[i]) begin
                rd_mux = {15'h0000, cfg_q[i]}; // [RULE2]
            end
        end
        if (hit_status) begin
            rd_mux = {28'h000_0000, lane_ok};
        end
        if (hit_error) begin
            rd_mux = {28'h000_0000, err_q};
        end
    end

    // Data and error are latched at the setup edge so both come from flops.
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end else if (setup && st_q == stc_pkg::STC_APB_IDLE) begin
            o_prdata  <= i_pwrite ? 32'h0000_0000 : rd_mux;
            o_pslverr <= ~mapped;
        end else if (i_psel && i_penable && o_pready) begin
            o_prdata  <= 32'h0000_0000;
            o_pslverr <= 1'b0;
        end
    end

endmodule : stc_tx_cfg

// ==== dv/stc_tx_cfg_properties.sv ====
// Concurrent checks on the ports of the transmit-channel configuration bank.
`timescale 1ns/1ps
module stc_tx_cfg_properties #(
    parameter int NUM_PORTS = 4
) (
    input wire logic                   i_clock,
    input wire logic                   i_rst,
    input wire logic                   i_psel,
    input wire logic                   i_penable,
    input wire logic                   i_pwrite,
    input wire logic [11:0]            i_paddr,
    input wire logic [31:0]            i_pwdata,
    input wire logic [3:0]             i_pstrb,
    input wire logic [31:0]            o_prdata,
    input wire logic                   o_pready,
    input wire logic                   o_pslverr,
    input wire logic [NUM_PORTS-1:0]   o_transmitter_on,
    input wire logic [NUM_PORTS-1:0]   o_fixed_phase_en,
    input wire logic [NUM_PORTS*4-1:0] o_tx_preemph_level,
    input wire logic [NUM_PORTS*3-1:0] o_tx_swing,
    input wire logic [NUM_PORTS-1:0]   o_common_mode_raise,
    input wire logic [NUM_PORTS-1:0]   o_tx_polarity_flip,
    input wire logic [NUM_PORTS*2-1:0] o_tx_rate,
    input wire logic [NUM_PORTS*3-1:0] o_parallel_width_sel,
    input wire logic [NUM_PORTS-1:0]   o_sample_stb
);
    // ------------------------------------------------------------------
    // Port 0 stands for all lanes; the lanes share one implementation.
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    logic hit;
    assign hit = (i_paddr[11:4] == 8'h11 && i_paddr[1:0] == 2'h0
                  && int'(i_paddr[3:2]) < NUM_PORTS)
                 || i_paddr == 12'h140 || i_paddr == 12'h144;

    sequence seq_setup;
        i_psel && !i_penable && !o_pready;
    endsequence
    sequence seq_access;
        i_psel && i_penable && o_pready;
    endsequence

    pready_answer_a: assert property (seq_setup |=> o_pready)
        else $error("pready missing after setup");
    pready_pulse_a: assert property (o_pready |=> !o_pready)
        else $error("pready longer than one cycle");
    addr_decode_a: assert property (o_pready |-> o_pslverr == !hit)
        else $error("pslverr does not match address map");
    rdata_idle_a: assert property (!o_pready |-> o_prdata == 32'h0)
        else $error("read data outside access cycle");
    rsvd_zero_a: assert property (o_pready && !i_pwrite |-> o_prdata[31:17] == 15'h0)
        else $error("upper bits read nonzero");
    write_pass_a: assert property (seq_access ##0 (i_pwrite
        && i_paddr == 12'h110 && i_pstrb == 4'hF) |-> ##2
        (o_tx_preemph_level[3:0] == $past(i_pwdata[15:12], 2)
        && o_tx_swing[2:0] == $past(i_pwdata[11:9], 2)
        && o_common_mode_raise[0] == $past(i_pwdata[8], 2)
        && o_tx_polarity_flip[0] == $past(i_pwdata[7], 2)
        && o_tx_rate[1:0] == $past(i_pwdata[6:5], 2)
        && o_fixed_phase_en[0] == $past(i_pwdata[16], 2)))
        else $error("lane fields differ from written word");
    lane_gate_a: assert property (o_transmitter_on[0] |-> o_fixed_phase_en[0]
        && o_parallel_width_sel[2:0] == 3'h0 && o_tx_rate[1:0] != 2'h3)
        else $error("lane on with invalid setup");
    stb_full_a: assert property ((o_transmitter_on[0] && o_tx_rate[1:0] == 2'h0)[*3]
        |-> o_sample_stb[0])
        else $error("full rate strobe missing");
    stb_half_a: assert property (o_sample_stb[0] && o_tx_rate[1:0] == 2'h1
        ##1 o_tx_rate[1:0] == 2'h1 |-> !o_sample_stb[0])
        else $error("half rate strobe too dense");
endmodule : stc_tx_cfg_properties

bind stc_tx_cfg stc_tx_cfg_properties #(.NUM_PORTS(NUM_PORTS)) i_props (.*);

// ==== dv/stc_tx_cfg_tb.sv ====
// Self-checking testbench for the transmit-channel configuration bank.
`timescale 1ns/1ps
module stc_tx_cfg_tb;
    // ------------------------------------------------------------------
    // Bench signals, APB master and checks
    // ------------------------------------------------------------------
    logic        clock   = 1'b0;
    logic        rst     = 1'b1;
    logic        psel    = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite  = 1'b0;
    logic [11:0] paddr   = 12'h0;
    logic [31:0] pwdata  = 32'h0;
    logic [3:0]  pstrb   = 4'hF;
    logic [31:0] prdata, r;
    logic        pready, pslverr, e;
    logic [3:0]  on, fix, cmr, pol, stb;
    logic [15:0] pre;
    logic [11:0] swg, wid;
    logic [7:0]  rate;
    int          mismatches = 0;
    int          comparisons = 0;

    always #2.5 clock = ~clock;

    stc_tx_cfg #(.NUM_PORTS(4)) i_dut (.i_clock(clock), .i_rst(rst), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
        .o_transmitter_on(on), .o_fixed_phase_en(fix), .o_tx_preemph_level(pre),
        .o_tx_swing(swg), .o_common_mode_raise(cmr), .o_tx_polarity_flip(pol),
        .o_tx_rate(rate), .o_parallel_width_sel(wid), .o_sample_stb(stb));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // The request is held until pready is seen high at a rising edge.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s = 4'hF);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clock);
        penable <= 1'b1;
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 20);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) mismatches++;
    endtask : apb

    function automatic logic [11:0] adr(input int p);
        return 12'h110 + 12'(4 * p);
    endfunction : adr

    task automatic test_reset;
        for (int p = 0; p < 4; p++) begin
            apb(1'b0, adr(p), 32'h0);
            check("cfg after reset", r, 32'h0);
            check("cfg error", {31'h0, e}, 32'h0);
        end
        check("lane bits", {12'h0, on, fix, cmr, pol, stb}, 32'h0);
        check("lane fields", {pre, swg, rate[3:0]}, 32'h0);
        check("lane rate width", {12'h0, rate, wid}, 32'h0);
        $display("test_reset done");
    endtask : test_reset

    task automatic test_fields;
        for (int p = 0; p < 4; p++) begin
            apb(1'b1, adr(p), 32'hFFFF_FFFF);
            apb(1'b0, adr(p), 32'h0);
            check("cfg readback", r, 32'h0001_FFFF);
            check("fields", {fix[p], pre[4*p+:4], swg[3*p+:3], cmr[p],
                pol[p], rate[2*p+:2], wid[3*p+:3]}, 32'h7FFF);
            check("lane reserved", {31'h0, on[p]}, 32'h0);
            apb(1'b1, adr(p), 32'h0);
        end
        $display("test_fields done");
    endtask : test_fields

    // Every port runs every legal rate, so port 0 also exercises the strobe checks.
    task automatic test_enable;
        logic [3:0]  de;
        logic [2:0]  sw;
        logic [1:0]  rt;
        logic [31:0] w;
        int          cnt;
        for (int p = 0; p < 4; p++) begin
            for (int k = 0; k < 3; k++) begin
                de = 4'(p * 5 + k + 1);
                sw = 3'(p + k + 2);
                rt = 2'(k);
                w = {15'h0, 1'b1, de, sw, p[0], p[1], rt, 5'h01};
                apb(1'b1, adr(p), w);
                repeat (2) @(posedge clock);
                check("fields", {fix[p], pre[4*p+:4], swg[3*p+:3], cmr[p],
                    pol[p], rate[2*p+:2], wid[3*p+:3]}, {17'h0, w[16:2]});
                check("swing", {29'h0, swg[3*p+:3]}, {29'h0, sw});
                check("polarity", {30'h0, pol[p], cmr[p]}, {30'h0, p[1], p[0]});
                check("lane on", {28'h0, on}, 32'(1 << p));
                cnt = 0;
                repeat (12) begin
                    @(posedge clock);
                    cnt += int'(stb[p] === 1'b1);
                end
                check("strobe count", cnt, 32'(12 >> rt));
                w[0] = 1'b0;
                apb(1'b1, adr(p), w);
                repeat (2) @(posedge clock);
                check("lane off", {28'h0, on}, 32'h0);
            end
            apb(1'b1, adr(p), 32'h0001_0000);
        end
        $display("test_enable done");
    endtask : test_enable

    task automatic test_strobe;
        apb(1'b1, adr(0), 32'h0);
        apb(1'b1, adr(0), 32'hFFFF_FFFF, 4'h2);
        apb(1'b0, adr(0), 32'h0);
        check("strobe lane 1", r, 32'h0000_FF00);
        apb(1'b1, adr(0), 32'hFFFF_FFFF, 4'hC);
        apb(1'b0, adr(0), 32'h0);
        check("strobe lanes 2 3", r, 32'h0001_FF00);
        apb(1'b1, adr(0), 32'hFFFF_FFFF, 4'h1);
        apb(1'b1, adr(0), 32'h0, 4'h6);
        apb(1'b0, adr(0), 32'h0);
        check("strobe lane 0", r, 32'h0000_00FF);
        apb(1'b1, adr(0), 32'h0);
        $display("test_strobe done");
    endtask : test_strobe

    task automatic test_status;
        apb(1'b1, 12'h144, 32'h0000_000F);
        apb(1'b0, 12'h144, 32'h0);
        check("error cleared", r, 32'h0);
        apb(1'b1, adr(1), 32'h0001_0001);
        apb(1'b0, 12'h140, 32'h0);
        check("status", r, 32'h0000_0002);
        apb(1'b1, 12'h140, 32'hFFFF_FFFF);
        check("status write", {31'h0, e}, 32'h0);
        apb(1'b0, 12'h144, 32'h0);
        check("error quiet", r, 32'h0);
        apb(1'b1, adr(1), 32'h0000_0001);
        apb(1'b0, 12'h144, 32'h0);
        check("error flag", r, 32'h0000_0002);
        apb(1'b1, 12'h144, 32'h0000_0002);
        apb(1'b0, 12'h144, 32'h0);
        check("error clear", r, 32'h0);
        $display("test_status done");
    endtask : test_status

    task automatic test_unmapped;
        apb(1'b1, 12'h110, 32'h0001_0000);
        apb(1'b0, 12'h120, 32'h0);
        check("unmapped read", r, 32'h0);
        check("unmapped error", {31'h0, e}, 32'h1);
        apb(1'b1, 12'h10C, 32'h0001_0001);
        check("unmapped write", {31'h0, e}, 32'h1);
        apb(1'b0, 12'h110, 32'h0);
        check("port0 unchanged", r, 32'h0001_0000);
        $display("test_unmapped done");
    endtask : test_unmapped

    task automatic test_midreset;
        apb(1'b1, adr(2), 32'h0001_FF81);
        repeat (2) @(posedge clock);
        check("lane on before reset", {28'h0, on}, 32'h4);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        check("lane bits in reset", {12'h0, on, fix, cmr, pol, stb}, 32'h0);
        apb(1'b0, adr(2), 32'h0);
        check("cfg after mid reset", r, 32'h0);
        $display("test_midreset done");
    endtask : test_midreset

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    // A hang would otherwise never reach the verdict.
    initial begin
        #100000;
        mismatches++;
        give_verdict();
    end

    initial begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        test_reset();
        test_fields();
        test_enable();
        test_strobe();
        test_status();
        test_unmapped();
        test_midreset();
        give_verdict();
    end
endmodule : stc_tx_cfg_tb
